/* File: bench/sbc_bus_controller_monitor.sv */
// Port checker for the status decoding bus controller
`timescale 1ns/1ns
module sbc_bus_controller_monitor (
	input wire logic clk,
	input wire logic srst,
	input wire logic cycle_status_bit0_n,
	input wire logic cycle_status_bit1_n,
	input wire logic cycle_status_bit2_n,
	input wire logic bus_grant_n,
	input wire logic command_gate,
	input wire logic io_bus_mode_strap,
	input wire logic addr_latch_strobe,
	input wire logic data_xcvr_enable,
	input wire logic data_direction,
	input wire logic cascade_or_periph_enable,
	input wire logic mem_read_cmd_n,
	input wire logic mem_write_cmd_n,
	input wire logic early_mem_write_cmd_n,
	input wire logic io_read_cmd_n,
	input wire logic io_write_cmd_n,
	input wire logic early_io_write_cmd_n,
	input wire logic irq_acknowledge_cmd_n,
	input wire logic mem_cmd_oe,
	input wire logic io_cmd_oe
);
	wire logic idle = &{mem_read_cmd_n, mem_write_cmd_n, early_mem_write_cmd_n, io_read_cmd_n,
		io_write_cmd_n, early_io_write_cmd_n, irq_acknowledge_cmd_n};
	wire logic pas = cycle_status_bit0_n & cycle_status_bit1_n & cycle_status_bit2_n;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_passive_idle: assert property (pas[*4] |=> idle)
		else $error("command active in passive");
	a_gate_mask: assert property (!command_gate[*4] |=> idle && !data_xcvr_enable)
		else $error("command active with gate low");
	a_strobe_width: assert property (
		$rose(addr_latch_strobe) |=> addr_latch_strobe ##1 !addr_latch_strobe)
		else $error("strobe width wrong");
	a_cascade_ack: assert property (
		!io_bus_mode_strap[*4] ##0 cascade_or_periph_enable |-> addr_latch_strobe)
		else $error("cascade enable outside address phase");
	a_write_dir: assert property (!mem_write_cmd_n || !io_write_cmd_n |-> data_direction)
		else $error("write with receive direction");
	a_read_dir: assert property (!mem_read_cmd_n || !io_read_cmd_n |-> !data_direction)
		else $error("read with transmit direction");
	a_grant_min: assert property ($rose(mem_cmd_oe) |-> !$past(bus_grant_n, 27))
		else $error("enable too early after grant");
	a_grant_max: assert property ($fell(bus_grant_n) |-> ##[1:62] (mem_cmd_oe || bus_grant_n))
		else $error("enable too late after grant");
	a_grant_drop: assert property (bus_grant_n[*3] |-> !mem_cmd_oe)
		else $error("drivers kept after grant loss");
	a_io_mode: assert property (io_bus_mode_strap[*3] |-> io_cmd_oe)
		else $error("io drivers off in io mode");
	a_early_first: assert property ($fell(mem_write_cmd_n) |-> !early_mem_write_cmd_n)
		else $error("normal write before early write");
endmodule : sbc_bus_controller_monitor
bind sbc_bus_controller sbc_bus_controller_monitor u_mon (.*);

/* File: bench/sbc_cpu_model.sv */
// Processor status driver and transparent address latch
`timescale 1ns/1ns
module sbc_cpu_model (
	input  wire logic       clk,
	input  wire logic [2:0] code,
	input  wire logic       addr_latch_strobe,
	input  wire logic [7:0] addr,
	output logic      [2:0] status_n = 3'h7,
	output logic      [7:0] latched
);
	always @(posedge clk) begin
		status_n <= code;
	end
	always_latch begin
		if (addr_latch_strobe) begin
			latched <= addr;
		end
	end
endmodule : sbc_cpu_model

/* File: bench/tb_sbc_bus_controller.sv */
// Self-checking bench for the status decoding bus controller
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
	$display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_sbc_bus_controller;
	import sbc_pkg::*;
	logic clk = 0, srst = 1, bus_grant_n = 1, command_gate = 1, io_bus_mode_strap = 0;
	logic [2:0] code = 3'h7;
	logic [7:0] addr = 8'h00, latched;
	wire logic cycle_status_bit0_n, cycle_status_bit1_n, cycle_status_bit2_n;
	logic addr_latch_strobe, data_xcvr_enable, data_direction, cascade_or_periph_enable;
	logic mem_read_cmd_n, mem_write_cmd_n, early_mem_write_cmd_n, io_read_cmd_n;
	logic io_write_cmd_n, early_io_write_cmd_n, irq_acknowledge_cmd_n, mem_cmd_oe, io_cmd_oe;
	int n_fail = 0, compares = 0;
	wire logic [6:0] cmds = {irq_acknowledge_cmd_n, io_read_cmd_n, io_write_cmd_n,
		early_io_write_cmd_n, mem_read_cmd_n, mem_write_cmd_n, early_mem_write_cmd_n};
	sbc_bus_controller dut_u (
		.clk                      (clk),
		.srst                     (srst),
		.cycle_status_bit0_n      (cycle_status_bit0_n),
		.cycle_status_bit1_n      (cycle_status_bit1_n),
		.cycle_status_bit2_n      (cycle_status_bit2_n),
		.bus_grant_n              (bus_grant_n),
		.command_gate             (command_gate),
		.io_bus_mode_strap        (io_bus_mode_strap),
		.addr_latch_strobe        (addr_latch_strobe),
		.data_xcvr_enable         (data_xcvr_enable),
		.data_direction           (data_direction),
		.cascade_or_periph_enable (cascade_or_periph_enable),
		.mem_read_cmd_n           (mem_read_cmd_n),
		.mem_write_cmd_n          (mem_write_cmd_n),
		.early_mem_write_cmd_n    (early_mem_write_cmd_n),
		.io_read_cmd_n            (io_read_cmd_n),
		.io_write_cmd_n           (io_write_cmd_n),
		.early_io_write_cmd_n     (early_io_write_cmd_n),
		.irq_acknowledge_cmd_n    (irq_acknowledge_cmd_n),
		.mem_cmd_oe               (mem_cmd_oe),
		.io_cmd_oe                (io_cmd_oe)
	);
	sbc_cpu_model cpu_u (.clk(clk), .code(code), .addr_latch_strobe(addr_latch_strobe),
		.addr(addr), .latched(latched),
		.status_n({cycle_status_bit2_n, cycle_status_bit1_n, cycle_status_bit0_n}));
	always #2 clk = ~clk;
	function automatic logic [6:0] exp_cmd(input logic [2:0] c);
		case (c)
			3'h0: exp_cmd = 7'h3F;
			3'h1: exp_cmd = 7'h5F;
			3'h2: exp_cmd = 7'h67;
			3'h4, 3'h5: exp_cmd = 7'h7B;
			3'h6: exp_cmd = 7'h7C;
			default: exp_cmd = 7'h7F;
		endcase
	endfunction : exp_cmd
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic results;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results
	task automatic t_decode;
		for (int c = 0; c < 7; c++) begin
			addr = 8'hA0 | 8'(c);
			code = 3'(c);
			tick(12);
			`CHK(cmds, exp_cmd(3'(c)))
			`CHK(data_direction, (c == 2 || c == 6))
			`CHK(data_xcvr_enable, (c != 3))
			addr = 8'h00;
			code = 3'h7;
			tick(6);
			`CHK(latched, 8'hA0 | 8'(c))
			`CHK(cmds, 7'h7F)
		end
		$display("decode test done");
	endtask : t_decode
	task automatic t_gate;
		command_gate = 0;
		code = 3'h5;
		tick(12);
		`CHK(cmds, 7'h7F)
		`CHK(data_xcvr_enable, 1'b0)
		command_gate = 1;
		tick(6);
		`CHK(mem_read_cmd_n, 1'b0)
		`CHK(data_xcvr_enable, 1'b1)
		code = 3'h7;
		tick(6);
		$display("gate test done");
	endtask : t_gate
	task automatic t_grant;
		int n;
		int dt;
		bus_grant_n = 1;
		tick(4);
		`CHK(mem_cmd_oe, 1'b0)
		code = 3'h5;
		tick(12);
		`CHK(mem_read_cmd_n, 1'b1)
		bus_grant_n = 0;
		n = 0;
		while (mem_cmd_oe !== 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		dt = n * CLK_PERIOD_NS - 1;
		`CHK((dt >= GRANT_MIN_NS && dt <= GRANT_MAX_NS), 1'b1)
		tick(4);
		`CHK(mem_read_cmd_n, 1'b0)
		code = 3'h7;
		tick(6);
		$display("grant test done");
	endtask : t_grant
	task automatic t_iob;
		io_bus_mode_strap = 1;
		bus_grant_n = 1;
		code = 3'h1;
		tick(12);
		`CHK(io_cmd_oe, 1'b1)
		`CHK(mem_cmd_oe, 1'b0)
		`CHK(io_read_cmd_n, 1'b0)
		`CHK(cascade_or_periph_enable, 1'b0)
		code = 3'h7;
		tick(6);
		`CHK(cascade_or_periph_enable, 1'b1)
		io_bus_mode_strap = 0;
		bus_grant_n = 0;
		tick(40);
		$display("io mode test done");
	endtask : t_iob
	initial begin
		#20000;
		n_fail++;
		results();
	end
	initial begin
		tick(12);
		srst = 0;
		tick(1);
		`CHK(cmds, 7'h7F)
		`CHK(addr_latch_strobe, 1'b0)
		`CHK(data_xcvr_enable, 1'b0)
		bus_grant_n = 0;
		tick(40);
		t_decode();
		t_gate();
		t_grant();
		t_iob();
		results();
	end
endmodule : tb_sbc_bus_controller

/* File: hw/sbc_bus_controller.sv */
// Status decoding bus controller: cycle sequencer, command decode, grant gating
`timescale 1ns/1ns
module sbc_bus_controller #(
	parameter int ALE_CYC       = sbc_pkg::ALE_HIGH_CYC,
	parameter int WRITE_LAG     = sbc_pkg::WRITE_LAG_CYC,
	parameter int GRANT_WAIT    = sbc_pkg::GRANT_WAIT_CYC
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic cycle_status_bit0_n,
	input  wire logic cycle_status_bit1_n,
	input  wire logic cycle_status_bit2_n,
	input  wire logic bus_grant_n,
	input  wire logic command_gate,
	input  wire logic io_bus_mode_strap,
	output logic      addr_latch_strobe,
	output logic      data_xcvr_enable,
	output logic      data_direction,
	output logic      cascade_or_periph_enable,
	output logic      mem_read_cmd_n,
	output logic      mem_write_cmd_n,
	output logic      early_mem_write_cmd_n,
	output logic      io_read_cmd_n,
	output logic      io_write_cmd_n,
	output logic      early_io_write_cmd_n,
	output logic      irq_acknowledge_cmd_n,
	output logic      mem_cmd_oe,
	output logic      io_cmd_oe
);
	import sbc_pkg::*;

	localparam int SYNC_W = 6;
	// Sync init: system mode, gate off, grant off, passive status
	localparam logic [SYNC_W-1:0] SYNC_INIT = {1'b0, 1'b0, 1'b1, 3'h7};

	// Synchronised pins
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins_s;
	logic [2:0]        status_s;
	logic              grant_n_s;
	logic              gate_s;
	logic              strap_s;

	assign pins_raw = {io_bus_mode_strap, command_gate, bus_grant_n,
		cycle_status_bit2_n, cycle_status_bit1_n, cycle_status_bit0_n};

	sbc_sync #(
		.WIDTH (SYNC_W),
		.INIT  (SYNC_INIT)
	) u_sync (
		.clk      (clk),
		.srst     (srst),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);

	assign status_s  = pins_s[2:0];
	assign grant_n_s = pins_s[3];
	assign gate_s    = pins_s[4];
	assign strap_s   = pins_s[5];

	// Sequencer state
	sbc_state_t       state_q;
	sbc_state_t       state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [2:0]       code_q;
	logic [2:0]       code_d;

	// Grant qualification
	logic [CNT_W-1:0] gwait_q;
	logic [CNT_W-1:0] gwait_d;
	logic             grant_ok_q;
	logic             grant_ok_d;

	// Registered pins
	logic ale_q;
	logic ale_d;
	logic den_q;
	logic den_d;
	logic dtr_q;
	logic dtr_d;
	logic dual_q;
	logic dual_d;
	logic mrd_q;
	logic mrd_d;
	logic mwr_q;
	logic mwr_d;
	logic amwr_q;
	logic amwr_d;
	logic ird_q;
	logic ird_d;
	logic iwr_q;
	logic iwr_d;
	logic aiwr_q;
	logic aiwr_d;
	logic irq_acknowledge_cmd_n_q;
	logic irq_acknowledge_cmd_n_d;

	// Decode of the latched cycle
	// status code map
	wire cyc_irq_acknowledge_cmd_n   = (code_q == ST_IRQ_ACKNOWLEDGE_CMD_N);
	wire cyc_io_rd  = (code_q == ST_IO_RD);
	wire cyc_io_wr  = (code_q == ST_IO_WR);
	wire cyc_mem_rd = (code_q == ST_CODE_RD) || (code_q == ST_MEM_RD);
	wire cyc_mem_wr = (code_q == ST_MEM_WR);
	wire cyc_io     = sbc_is_io(code_q);
	wire cyc_mem    = sbc_is_mem(code_q);
	wire cyc_write  = sbc_is_write(code_q);

	// Phase decode
	wire in_addr    = (state_q == S_ADDR);
	wire in_data    = (state_q == S_EARLY) || (state_q == S_LATE);
	wire in_late    = (state_q == S_LATE);
	wire passive_s  = (status_s == ST_PASSIVE);
	wire new_cycle  = (state_q == S_IDLE) && !passive_s;
	wire cnt_done   = (cnt_q == CNT_W'(0));

	// mode select
	// Strap read continuously, never latched
	wire io_mode    = strap_s;

	// I/O commands ignore grant in I/O-bus mode
	wire io_ok      = io_mode || grant_ok_q;
	wire mem_ok     = grant_ok_q;

	// gate low kills commands, data and peripheral enables
	wire cmd_en     = gate_s;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		code_d  = code_q;
		case (state_q)
			S_IDLE: begin
				if (new_cycle) begin
					code_d  = status_s;
					cnt_d   = CNT_W'(ALE_CYC - 1);
					state_d = S_ADDR;
				end
			end
			S_ADDR: begin
				// Passive before the data phase: no command at all
				if (cnt_done && passive_s) begin
					state_d = S_DONE;
				end else if (cnt_done) begin
					cnt_d   = CNT_W'(WRITE_LAG - 1);
					state_d = S_EARLY;
				end else begin
					cnt_d = cnt_q - CNT_W'(1);
				end
			end
			S_EARLY: begin
				if (passive_s) begin
					state_d = S_DONE;
				end else if (cnt_done) begin
					state_d = S_LATE;
				end else begin
					cnt_d = cnt_q - CNT_W'(1);
				end
			end
			S_LATE: begin
				if (passive_s) begin
					state_d = S_DONE;
				end
			end
			S_DONE: begin
				// Forget the cycle so IDLE waits for a fresh code
				code_d  = ST_PASSIVE;
				state_d = S_IDLE;
			end
			default: begin
				code_d  = ST_PASSIVE;
				state_d = S_IDLE;
			end
		endcase
	end

	always_comb begin
		gwait_d    = gwait_q;
		grant_ok_d = grant_ok_q;
		// Any synced high restarts the wait
		if (grant_n_s) begin
			gwait_d    = '0;
			grant_ok_d = 1'b0;
		end else if (gwait_q >= CNT_W'(GRANT_WAIT - 1)) begin
			grant_ok_d = 1'b1;
		end else begin
			gwait_d = gwait_q + CNT_W'(1);
		end
	end

	assign ale_d = in_addr;

	assign dtr_d = (in_addr || in_data || state_q == S_DONE) && cyc_write;

	assign den_d = in_data && cmd_en && (io_mode ? cyc_mem : (cyc_mem || cyc_io));

	// dual pin by strap
	// Cascade enable ignores the gate, peripheral enable obeys it
	assign dual_d = io_mode
		? !(in_data && cmd_en && cyc_io)
		: (in_addr && cyc_irq_acknowledge_cmd_n);

	// Active-low command level from phase, gate, permission and cycle class
	function automatic logic cmd_level_n(input logic phase, input logic gate,
		input logic ok, input logic cyc);
		cmd_level_n = !(phase && gate && ok && cyc);
	endfunction : cmd_level_n

	// early writes with reads, normal writes late
	assign mrd_d  = cmd_level_n(in_data, cmd_en, mem_ok, cyc_mem_rd);
	assign amwr_d = cmd_level_n(in_data, cmd_en, mem_ok, cyc_mem_wr);
	assign mwr_d  = cmd_level_n(in_late, cmd_en, mem_ok, cyc_mem_wr);
	assign ird_d  = cmd_level_n(in_data, cmd_en, io_ok, cyc_io_rd);
	assign aiwr_d = cmd_level_n(in_data, cmd_en, io_ok, cyc_io_wr);
	assign iwr_d  = cmd_level_n(in_late, cmd_en, io_ok, cyc_io_wr);
	assign irq_acknowledge_cmd_n_d = cmd_level_n(in_data, cmd_en, io_ok, cyc_irq_acknowledge_cmd_n);

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q    <= S_IDLE;
			cnt_q      <= '0;
			code_q     <= ST_PASSIVE;
			gwait_q    <= '0;
			grant_ok_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			code_q     <= code_d;
			gwait_q    <= gwait_d;
			grant_ok_q <= grant_ok_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mrd_q  <= CMD_IDLE_N;
			mwr_q  <= CMD_IDLE_N;
			amwr_q <= CMD_IDLE_N;
			ird_q  <= CMD_IDLE_N;
			iwr_q  <= CMD_IDLE_N;
			aiwr_q <= CMD_IDLE_N;
			irq_acknowledge_cmd_n_q <= CMD_IDLE_N;
		end else begin
			mrd_q  <= mrd_d;
			mwr_q  <= mwr_d;
			amwr_q <= amwr_d;
			ird_q  <= ird_d;
			iwr_q  <= iwr_d;
			aiwr_q <= aiwr_d;
			irq_acknowledge_cmd_n_q <= irq_acknowledge_cmd_n_d;
		end
	end

	// Control pins
	always_ff @(posedge clk) begin
		if (srst) begin
			ale_q  <= 1'b0;
			den_q  <= 1'b0;
			dtr_q  <= 1'b0;
			dual_q <= 1'b0;
		end else begin
			ale_q  <= ale_d;
			den_q  <= den_d;
			dtr_q  <= dtr_d;
			dual_q <= dual_d;
		end
	end

	assign addr_latch_strobe        = ale_q;
	assign data_xcvr_enable         = den_q;
	assign data_direction           = dtr_q;
	assign cascade_or_periph_enable = dual_q;
	assign mem_read_cmd_n           = mrd_q;
	assign mem_write_cmd_n          = mwr_q;
	assign early_mem_write_cmd_n    = amwr_q;
	assign io_read_cmd_n            = ird_q;
	assign io_write_cmd_n           = iwr_q;
	assign early_io_write_cmd_n     = aiwr_q;
	assign irq_acknowledge_cmd_n    = irq_acknowledge_cmd_n_q;

	// raw grant pin cuts the drivers without waiting for an edge
	wire grant_pin_low = !bus_grant_n;
	wire cmd_drive     = grant_ok_q && !grant_n_s && grant_pin_low;
	// I/O drivers always on in I/O-bus mode
	wire io_drive      = io_mode || cmd_drive;

	assign mem_cmd_oe = cmd_drive;
	assign io_cmd_oe  = io_drive;

endmodule : sbc_bus_controller

/* File: hw/sbc_pkg.sv */
// Constants, types and helpers for the status decoding bus controller
// Function
// - Decode three status bits into command and control outputs on clock edges.
// - Passive status code keeps every command output high and inactive.
// - Address strobe is active high; latches capture on its falling edge.
// - Data transceiver enable goes high during the data part of memory cycles, and of I/O cycles in system-bus mode.
// - Direction output high for writes, low for reads.
// - Command outputs enabled 110 ns to 250 ns after grant goes low.
// - Grant going high releases command drivers without waiting.
// - In I/O-bus mode the grant does not affect I/O command outputs.
// - Command gate low forces commands, data and peripheral enables inactive.
// - Command gate high lets commands and transceiver enables work normally.
// - Strap high selects I/O-bus mode, strap low selects system-bus mode.
// - Status map: acknowledge, I/O read, I/O write, halt, memory read/write, passive.
// - Dual pin: cascade enable in acknowledge when strap low, peripheral enable otherwise.
// - I/O-bus mode issues I/O commands at once, steering peripheral transceiver.
// - Early write strobes start with read commands, before normal writes.
package sbc_pkg;

	// Status codes, bits 2..1..0
	localparam logic [2:0] ST_IRQ_ACKNOWLEDGE_CMD_N    = 3'h0;
	localparam logic [2:0] ST_IO_RD   = 3'h1;
	localparam logic [2:0] ST_IO_WR   = 3'h2;
	localparam logic [2:0] ST_HALT    = 3'h3;
	localparam logic [2:0] ST_CODE_RD = 3'h4;
	localparam logic [2:0] ST_MEM_RD  = 3'h5;
	localparam logic [2:0] ST_MEM_WR  = 3'h6;
	localparam logic [2:0] ST_PASSIVE = 3'h7;

	// Timing in ns and derived clock counts
	localparam int CLK_PERIOD_NS  = 4;
	localparam int GRANT_MIN_NS   = 110;
	localparam int GRANT_MAX_NS   = 250;
	localparam int GRANT_MIN_CYC  = (GRANT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GRANT_MAX_CYC  = GRANT_MAX_NS / CLK_PERIOD_NS;
	localparam int SYNC_STAGES    = 2;
	// One extra count: the pin may fall just before a sync edge
	localparam int GRANT_WAIT_CYC = GRANT_MIN_CYC - SYNC_STAGES + 1;
	localparam int ALE_HIGH_CYC   = 2;
	localparam int WRITE_LAG_CYC  = 4;
	localparam int CNT_W          = 6;

	// Reset values of the pins
	localparam logic CMD_IDLE_N = 1'b1;
	localparam logic PERIPH_DATA_XCVR_ENABLE_N_IDLE_N = 1'b1;

	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_EARLY,
		S_LATE,
		S_DONE
	} sbc_state_t;

	// I/O class cycle: read, write or acknowledge
	function automatic logic sbc_is_io(input logic [2:0] code);
		sbc_is_io = (code == ST_IO_RD) || (code == ST_IO_WR) || (code == ST_IRQ_ACKNOWLEDGE_CMD_N);
	endfunction : sbc_is_io

	// Memory class cycle: code fetch, read or write
	function automatic logic sbc_is_mem(input logic [2:0] code);
		sbc_is_mem = (code == ST_CODE_RD) || (code == ST_MEM_RD) || (code == ST_MEM_WR);
	endfunction : sbc_is_mem

	// Write class cycle
	function automatic logic sbc_is_write(input logic [2:0] code);
		sbc_is_write = (code == ST_IO_WR) || (code == ST_MEM_WR);
	endfunction : sbc_is_write

endpackage : sbc_pkg

/* File: hw/sbc_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module sbc_sync #(
	parameter int        WIDTH   = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= INIT;
			sync_q <= INIT;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule : sbc_sync
